//--- rtl/rtc_core.sv
// Real-time clock timekeeping core with APB register slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"

module rtc_core
   import rtc_pkg::*;
#(
   parameter int PRESCALE = `RTC_SRC_HZ
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,
   input  wire logic        xtal_32k_i,
   input  wire logic        ext_32k_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o
);

   // ==========================================================
   // Elaboration checks
   if (PRESCALE < 2 || PRESCALE > (1 << `RTC_PRESC_W)) begin : g_chk_presc
      $error("PRESCALE out of range");
   end
   // Edge detection needs several system clocks per source period
   if (`RTC_SYS_HZ < 4 * `RTC_SRC_HZ) begin : g_chk_ratio
      $error("system clock too slow for 32kHz source");
   end

   localparam logic [`RTC_PRESC_W-1:0] PRESC_MAX = `RTC_PRESC_W'(PRESCALE - 1);

   // ==========================================================
   // Code conversion helpers
   function automatic logic [7:0] enc(input logic [6:0] v, input logic b);
      logic [3:0] t;
      logic [3:0] u;
      t = 4'(v / 7'h0A);
      u = 4'(v % 7'h0A);
      return b ? {t, u} : {1'b0, v};
   endfunction

   function automatic logic [6:0] dec(input logic [7:0] d, input logic b);
      logic [6:0] t;
      t = 7'({3'h0, d[7:4]} * 7'h0A);
      return b ? 7'(t + {3'h0, d[3:0]}) : d[6:0];
   endfunction

   function automatic logic [4:0] dim(input logic [3:0] m, input logic [6:0] y);
      logic [4:0] r;
      case (m)
         4'h2:                   r = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: r = 5'h1E;
         default:                r = 5'h1F;
      endcase
      return r;
   endfunction

   // ==========================================================
   // State and next state
   rtc_state_t  st;
   rtc_state_t  next_st;
   logic [9:0]  idx;
   logic        setup;
   logic        acc;
   logic        hit;
   logic        wr;
   logic        edge32;
   logic        tick;
   logic [4:0]  hr12;
   logic [31:0] rd;
   logic [6:0]  w_a;
   logic [6:0]  w_b;
   logic [4:0]  w_h;

   always_comb begin
      next_st = st;
      idx     = paddr_i[11:2];
      setup   = psel_i & ~penable_i;
      acc     = psel_i & penable_i & st.pready;
      hit     = (paddr_i[1:0] == 2'h0) &&
                (idx == `RTC_IDX_SECMIN || idx == `RTC_IDX_HRDAY ||
                 idx == `RTC_IDX_DATE   || idx == `RTC_IDX_YEAR  ||
                 idx == `RTC_IDX_CTRL   || idx == `RTC_IDX_ISTAT ||
                 idx == `RTC_IDX_IMASK);
      wr      = acc & pwrite_i & hit;
      tick    = 1'b0;
      rd      = '0;
      w_a     = '0;
      w_b     = '0;
      w_h     = '0;

      // 32kHz source: two-stage synchroniser, then edge detect on stages 2 and 3
      next_st.sync = {st.sync[1], st.sync[0],
                      st.ctl.src_ext ? ext_32k_i : xtal_32k_i};
      edge32 = st.sync[1] & ~st.sync[2];

      // Stop takes hold only on a source edge, so the status is honest
      if (edge32) begin
         next_st.stopped = st.ctl.stop_req;
         if (st.ctl.tick_on && !st.ctl.stop_req) begin
            if (st.presc == PRESC_MAX) begin
               next_st.presc = '0;
               tick          = 1'b1;
            end else begin
               next_st.presc = st.presc + 1'b1;
            end
         end
      end

      // Calendar carry chain, stored in binary 24-hour form
      if (tick) begin
         if (st.tm.sec < `RTC_SEC_MAX) begin
            next_st.tm.sec = st.tm.sec + 6'h01;
         end else begin
            next_st.tm.sec = '0;
            if (st.tm.min < `RTC_SEC_MAX) begin
               next_st.tm.min = st.tm.min + 6'h01;
            end else begin
               next_st.tm.min = '0;
               if (st.tm.hr < `RTC_HR_MAX) begin
                  next_st.tm.hr = st.tm.hr + 5'h01;
               end else begin
                  next_st.tm.hr   = '0;
                  next_st.tm.wday = (st.tm.wday >= `RTC_WDAY_MAX) ?
                                    `RTC_WDAY_RST : st.tm.wday + 3'h1;
                  if (st.tm.date < dim(st.tm.mon, st.tm.year)) begin
                     next_st.tm.date = st.tm.date + 5'h01;
                  end else begin
                     next_st.tm.date = `RTC_DATE_RST;
                     if (st.tm.mon < `RTC_MON_MAX) begin
                        next_st.tm.mon = st.tm.mon + 4'h1;
                     end else begin
                        next_st.tm.mon  = `RTC_MON_RST;
                        next_st.tm.year = (st.tm.year >= `RTC_YEAR_MAX) ?
                                          '0 : st.tm.year + 7'h01;
                     end
                  end
               end
            end
         end
      end

      // Read view in the selected coding and hour format
      hr12 = (st.tm.hr == 5'h00) ? `RTC_HR_HALF :
             (st.tm.hr > `RTC_HR_HALF) ? st.tm.hr - `RTC_HR_HALF : st.tm.hr;
      case (idx)
         `RTC_IDX_SECMIN: begin
            rd[`RTC_F_SEC] = 7'(enc({1'b0, st.tm.sec}, st.ctl.bcd));
            rd[`RTC_F_MIN] = 7'(enc({1'b0, st.tm.min}, st.ctl.bcd));
         end
         `RTC_IDX_HRDAY: begin
            rd[`RTC_F_HR]   = 5'(enc({2'h0, st.ctl.h12 ? hr12 : st.tm.hr},
                                     st.ctl.bcd));
            rd[`RTC_B_PM]   = st.ctl.h12 && (st.tm.hr >= `RTC_HR_HALF);
            rd[`RTC_F_WDAY] = st.tm.wday;
         end
         `RTC_IDX_DATE: begin
            rd[`RTC_F_DATE] = 6'(enc({2'h0, st.tm.date}, st.ctl.bcd));
            rd[`RTC_F_MON]  = 5'(enc({3'h0, st.tm.mon}, st.ctl.bcd));
         end
         `RTC_IDX_YEAR: begin
            rd[`RTC_F_CENT] = 6'(enc(`RTC_CENTURY, st.ctl.bcd));
            rd[`RTC_F_YEAR] = enc(st.tm.year, st.ctl.bcd);
         end
         `RTC_IDX_CTRL: begin
            rd[`RTC_B_BCD]  = st.ctl.bcd;
            rd[`RTC_B_H12]  = st.ctl.h12;
            rd[`RTC_B_STOP] = st.ctl.stop_req;
            rd[`RTC_B_STS]  = st.stopped;
            rd[`RTC_B_SRC]  = st.ctl.src_ext;
            rd[`RTC_B_TICK] = st.ctl.tick_on;
         end
         `RTC_IDX_ISTAT: rd[`RTC_B_SECEV] = st.sec_ev;
         `RTC_IDX_IMASK: rd[`RTC_B_SECEV] = st.mask;
         default:        rd = '0;
      endcase

      // APB: zero-wait access phase; read data captured in setup
      next_st.pready  = setup;
      next_st.pslverr = setup & ~hit;
      if (setup) begin
         next_st.prdata = hit ? rd : '0;
      end

      // Out-of-range values are ignored field by field; a year of 128 or more is taken modulo 128 before its check
      if (wr) begin
         case (idx)
            `RTC_IDX_SECMIN: begin
               w_a = dec({1'b0, pwdata_i[`RTC_F_SEC]}, st.ctl.bcd);
               w_b = dec({1'b0, pwdata_i[`RTC_F_MIN]}, st.ctl.bcd);
               if (w_a <= 7'(`RTC_SEC_MAX)) next_st.tm.sec = w_a[5:0];
               if (w_b <= 7'(`RTC_SEC_MAX)) next_st.tm.min = w_b[5:0];
               next_st.presc = '0;
            end
            `RTC_IDX_HRDAY: begin
               w_a = dec({3'h0, pwdata_i[`RTC_F_HR]}, st.ctl.bcd);
               w_h = w_a[4:0];
               if (st.ctl.h12) begin
                  if (w_a >= 7'h01 && w_a <= 7'(`RTC_HR_HALF)) begin
                     next_st.tm.hr = ((w_h == `RTC_HR_HALF) ? 5'h00 : w_h) +
                                     (pwdata_i[`RTC_B_PM] ? `RTC_HR_HALF : 5'h00);
                  end
               end else if (w_a <= 7'(`RTC_HR_MAX)) begin
                  next_st.tm.hr = w_h;
               end
               if (pwdata_i[`RTC_F_WDAY] != 3'h0) begin
                  next_st.tm.wday = pwdata_i[`RTC_F_WDAY];
               end
               next_st.presc = '0;
            end
            `RTC_IDX_DATE: begin
               w_a = dec({2'h0, pwdata_i[`RTC_F_DATE]}, st.ctl.bcd);
               w_b = dec({3'h0, pwdata_i[`RTC_F_MON]}, st.ctl.bcd);
               if (w_a >= 7'h01 && w_a <= 7'h1F) next_st.tm.date = w_a[4:0];
               if (w_b >= 7'h01 && w_b <= 7'(`RTC_MON_MAX)) begin
                  next_st.tm.mon = w_b[3:0];
               end
               next_st.presc = '0;
            end
            `RTC_IDX_YEAR: begin
               w_a = dec(pwdata_i[`RTC_F_YEAR], st.ctl.bcd);
               if (w_a <= `RTC_YEAR_MAX) next_st.tm.year = w_a;
               next_st.presc = '0;
            end
            `RTC_IDX_CTRL: begin
               next_st.ctl.bcd      = pwdata_i[`RTC_B_BCD];
               next_st.ctl.h12      = pwdata_i[`RTC_B_H12];
               next_st.ctl.stop_req = pwdata_i[`RTC_B_STOP];
               next_st.ctl.src_ext  = pwdata_i[`RTC_B_SRC];
               next_st.ctl.tick_on  = pwdata_i[`RTC_B_TICK];
            end
            `RTC_IDX_IMASK: next_st.mask = pwdata_i[`RTC_B_SECEV];
            default: next_st.mask = st.mask;
         endcase
      end

      // Sticky event, write one to clear; a new tick wins over the clear
      if (wr && idx == `RTC_IDX_ISTAT && pwdata_i[`RTC_B_SECEV]) begin
         next_st.sec_ev = 1'b0;
      end
      if (tick) begin
         next_st.sec_ev = 1'b1;
      end
      next_st.irq = next_st.sec_ev & next_st.mask;
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st             <= '0;
         st.tm.wday     <= `RTC_WDAY_RST;
         st.tm.date     <= `RTC_DATE_RST;
         st.tm.mon      <= `RTC_MON_RST;
         st.ctl.tick_on <= 1'b1;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign prdata_o  = st.prdata;
   assign pready_o  = st.pready;
   assign pslverr_o = st.pslverr;
   assign irq_o     = st.irq;

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   chk_tick_gate: assert property (
      (ce_i && !st.ctl.tick_on && !wr) |=> $stable(st.presc) && $stable(st.tm))
      else $error("time moved with tick generator off");

   chk_stop_halts: assert property (
      (ce_i && st.ctl.stop_req && !wr) |=> $stable(st.tm))
      else $error("time moved under stop request");

   chk_stop_status: assert property (
      (ce_i && edge32) |=> (st.stopped == $past(st.ctl.stop_req)))
      else $error("stop status not taken at source edge");

   chk_status_sync: assert property (
      (ce_i && !edge32) |=> $stable(st.stopped))
      else $error("stop status changed between source edges");

   chk_sec_event: assert property (
      (ce_i && tick) |=> (st.sec_ev && st.presc == '0))
      else $error("seconds event or prescaler restart missing");

   chk_sec_roll: assert property (
      (ce_i && tick && !wr && st.tm.sec == `RTC_SEC_MAX) |=> (st.tm.sec == '0)
      ##0 (st.tm.min != $past(st.tm.min)))
      else $error("seconds did not roll into minutes");

   chk_ranges: assert property (
      st.tm.sec <= `RTC_SEC_MAX && st.tm.min <= `RTC_SEC_MAX
      && st.tm.hr <= `RTC_HR_MAX && st.tm.wday != 3'h0)
      else $error("time field out of range");

   chk_cal_range: assert property (
      st.tm.date != 5'h00 && st.tm.mon != 4'h0 && st.tm.mon <= `RTC_MON_MAX
      && st.tm.year <= `RTC_YEAR_MAX)
      else $error("calendar field out of range");

   chk_century: assert property (
      (ce_i && setup && hit && idx == `RTC_IDX_YEAR) |=>
      (st.prdata[`RTC_F_CENT] == (st.ctl.bcd ? 6'h20 : 6'h14)))
      else $error("century field wrong");

   chk_pm_24h: assert property (
      (ce_i && setup && idx == `RTC_IDX_HRDAY && !st.ctl.h12) |=>
      !st.prdata[`RTC_B_PM])
      else $error("PM bit set in 24-hour mode");

   chk_irq_level: assert property (
      st.irq == (st.sec_ev & st.mask))
      else $error("interrupt does not follow masked status");

   chk_wday_wrap: assert property (
      (ce_i && tick && !wr && st.tm.sec == `RTC_SEC_MAX && st.tm.min == `RTC_SEC_MAX
      && st.tm.hr == `RTC_HR_MAX && st.tm.wday == `RTC_WDAY_MAX) |=>
      (st.tm.wday == `RTC_WDAY_RST))
      else $error("weekday did not wrap to one");

   chk_year_wrap: assert property (
      (ce_i && tick && !wr && st.tm.sec == `RTC_SEC_MAX && st.tm.min == `RTC_SEC_MAX
      && st.tm.hr == `RTC_HR_MAX && st.tm.date == 5'h1F && st.tm.mon == `RTC_MON_MAX
      && st.tm.year == `RTC_YEAR_MAX) |=>
      (st.tm.year == '0 && st.tm.mon == `RTC_MON_RST && st.tm.date == `RTC_DATE_RST))
      else $error("year did not wrap to zero");

   chk_pm_bcd: assert property (
      (ce_i && setup && hit && idx == `RTC_IDX_HRDAY && st.ctl.bcd && st.ctl.h12
      && st.tm.hr == `RTC_HR_MAX) |=>
      (st.prdata[`RTC_F_HR] == 5'h11 && st.prdata[`RTC_B_PM]))
      else $error("eleven PM not shown in BCD 12-hour view");

   chk_year_drop: assert property (
      (ce_i && wr && !tick && idx == `RTC_IDX_YEAR && !st.ctl.bcd
      && pwdata_i[`RTC_F_YEAR] > 8'(`RTC_YEAR_MAX)) |=> $stable(st.tm.year))
      else $error("out-of-range year was stored");

   chk_stop_no_tick: assert property (
      (ce_i && st.ctl.stop_req) |-> !tick)
      else $error("tick issued under stop request");

   // A held ready would let one access phase write twice
   chk_ready_pulse: assert property (
      (ce_i && st.pready) |=> !st.pready)
      else $error("ready held longer than one cycle");

endmodule
`default_nettype wire

//--- rtl/rtc_params.svh
// Register map, field positions, reset values and timing constants of the RTC core
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// Register indices; the byte address is four times the index
`define RTC_IDX_SECMIN  10'h010
`define RTC_IDX_HRDAY   10'h011
`define RTC_IDX_DATE    10'h012
`define RTC_IDX_YEAR    10'h013
`define RTC_IDX_CTRL    10'h017
`define RTC_IDX_ISTAT   10'h018
`define RTC_IDX_IMASK   10'h019
// Field positions
`define RTC_F_SEC       6:0
`define RTC_F_MIN       14:8
`define RTC_F_HR        4:0
`define RTC_B_PM        5
`define RTC_F_WDAY      10:8
`define RTC_F_DATE      5:0
`define RTC_F_MON       12:8
`define RTC_F_CENT      13:8
`define RTC_F_YEAR      7:0
`define RTC_B_BCD       15
`define RTC_B_H12       14
`define RTC_B_STOP      11
`define RTC_B_STS       10
`define RTC_B_SRC       1
`define RTC_B_TICK      0
`define RTC_B_SECEV     0
// Ranges and reset values
`define RTC_SEC_MAX     6'h3B
`define RTC_HR_MAX      5'h17
`define RTC_HR_HALF     5'h0C
`define RTC_WDAY_MAX    3'h7
`define RTC_WDAY_RST    3'h1
`define RTC_DATE_RST    5'h01
`define RTC_MON_MAX     4'hC
`define RTC_MON_RST     4'h1
`define RTC_YEAR_MAX    7'h63
`define RTC_CENTURY     7'h14
// Timing
`define RTC_SRC_HZ      32768
`define RTC_SYS_HZ      20000000
`define RTC_PRESC_W     16
`endif

//--- rtl/rtc_pkg.sv
// Types shared by the RTC core
`include "rtc_params.svh"
package rtc_pkg;
   typedef struct packed {
      logic [5:0] sec;
      logic [5:0] min;
      logic [4:0] hr;
      logic [2:0] wday;
      logic [4:0] date;
      logic [3:0] mon;
      logic [6:0] year;
   } rtc_time_t;

   typedef struct packed {
      logic bcd;
      logic h12;
      logic stop_req;
      logic tick_on;
      logic src_ext;
   } rtc_ctrl_t;

   typedef struct packed {
      rtc_time_t                 tm;
      rtc_ctrl_t                 ctl;
      logic                      stopped;
      logic [2:0]                sync;
      logic [`RTC_PRESC_W-1:0]   presc;
      logic                      sec_ev;
      logic                      mask;
      logic                      irq;
      logic [31:0]               prdata;
      logic                      pready;
      logic                      pslverr;
   } rtc_state_t;
endpackage

//--- dv/rtc_timekeeping_core_test.sv
// Self-checking APB testbench for the RTC timekeeping core
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"

module rtc_timekeeping_core_test;
   import rtc_pkg::*;

   // ==========================================================
   // Clock, reset and stimulus signals
   // ==========================================================
   localparam int PRESC = 4;
   localparam int LIMIT = 10000;

   logic        ref_clk_i;
   logic        rstn_i;
   logic        ce_i;
   logic        xtal_32k_i;
   logic        ext_32k_i;
   logic        psel_i;
   logic        penable_i;
   logic        pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        irq_o;
   logic        xt_run;
   logic        ex_run;
   logic [2:0]  div = 3'h0;
   logic [31:0] rdat;
   logic        rerr;
   int          miscompares;
   int          checks;
   int          cycles = 0;

   rtc_core #(.PRESCALE(PRESC)) i_dut (
      .ref_clk_i  (ref_clk_i),
      .rstn_i     (rstn_i),
      .ce_i       (ce_i),
      .xtal_32k_i (xtal_32k_i),
      .ext_32k_i  (ext_32k_i),
      .psel_i     (psel_i),
      .penable_i  (penable_i),
      .pwrite_i   (pwrite_i),
      .paddr_i    (paddr_i),
      .pwdata_i   (pwdata_i),
      .prdata_o   (prdata_o),
      .pready_o   (pready_o),
      .pslverr_o  (pslverr_o),
      .irq_o      (irq_o)
   );

   always #25 ref_clk_i = ~ref_clk_i;

   // Source clock well below ref_clk/4; each source may be frozen on its own
   always @(posedge ref_clk_i) begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
         if (xt_run) xtal_32k_i <= ~xtal_32k_i;
         if (ex_run) ext_32k_i <= ~ext_32k_i;
      end
   end

   // ==========================================================
   // Reporting
   // ==========================================================
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_test(input string nm);
      $display("test %s done", nm);
   endtask

   // ==========================================================
   // APB master tasks
   // ==========================================================
   task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= {idx, 2'b00};
      pwdata_i  <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      // Waits for pready_o; only the bench timeout ends a wait that hangs
      do begin
         @(posedge ref_clk_i);
      end while (pready_o !== 1'b1);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic exp_rd(input logic [9:0] idx, input logic [31:0] e, input string nm);
      xfer(1'b0, idx, 32'h0);
      chk(nm, e, rdat);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_o !== 1'b1 && n < 400) begin
         @(posedge ref_clk_i);
         n++;
      end
      chk("irq_o", 32'h1, {31'h0, irq_o});
   endtask

   // Stop request, then poll the stop status bit until it is set
   task automatic stop_on(input logic [31:0] ctl);
      int n;
      n = 0;
      wr(`RTC_IDX_CTRL, ctl);
      do begin
         xfer(1'b0, `RTC_IDX_CTRL, 32'h0);
         n++;
      end while (rdat[`RTC_B_STS] !== 1'b1 && n < 40);
      chk("stop_status", 32'h1, {31'h0, rdat[`RTC_B_STS]});
   endtask

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      int n;
      ref_clk_i   = 1'b0;
      rstn_i      = 1'b0;
      ce_i        = 1'b1;
      xtal_32k_i  = 1'b0;
      ext_32k_i   = 1'b0;
      psel_i      = 1'b0;
      penable_i   = 1'b0;
      pwrite_i    = 1'b0;
      paddr_i     = 12'h000;
      pwdata_i    = 32'h0;
      xt_run      = 1'b0;
      ex_run      = 1'b0;
      miscompares = 0;
      checks      = 0;
      repeat (5) @(posedge ref_clk_i);
      rstn_i <= 1'b1;

      exp_rd(`RTC_IDX_SECMIN, 32'h0000_0000, "secmin");
      exp_rd(`RTC_IDX_HRDAY, 32'h0000_0100, "hrday");
      exp_rd(`RTC_IDX_DATE, 32'h0000_0101, "date");
      exp_rd(`RTC_IDX_YEAR, 32'h0000_1400, "year");
      exp_rd(`RTC_IDX_CTRL, 32'h0000_0001, "ctrl");
      exp_rd(`RTC_IDX_ISTAT, 32'h0000_0000, "istat");
      xfer(1'b0, 10'h020, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, rerr});
      chk("unmapped_data", 32'h0, rdat);
      end_test("reset");

      // Load last second of the century, then let it roll over
      xt_run = 1'b1;
      wr(`RTC_IDX_IMASK, 32'h1);
      stop_on(32'h0000_0801);
      wr(`RTC_IDX_SECMIN, 32'h0000_3B3B);
      wr(`RTC_IDX_HRDAY, 32'h0000_0717);
      wr(`RTC_IDX_DATE, 32'h0000_0C1F);
      wr(`RTC_IDX_YEAR, 32'h0000_3F63);
      exp_rd(`RTC_IDX_YEAR, 32'h0000_1463, "year_ro");
      wr(`RTC_IDX_YEAR, 32'h0000_0064);
      exp_rd(`RTC_IDX_YEAR, 32'h0000_1463, "year_max");
      wr(`RTC_IDX_ISTAT, 32'h1);
      repeat (200) @(posedge ref_clk_i);
      exp_rd(`RTC_IDX_SECMIN, 32'h0000_3B3B, "held");
      exp_rd(`RTC_IDX_ISTAT, 32'h0000_0000, "no_event");
      wr(`RTC_IDX_CTRL, 32'h0000_0001);
      wait_irq();
      exp_rd(`RTC_IDX_SECMIN, 32'h0000_0000, "roll_sm");
      exp_rd(`RTC_IDX_HRDAY, 32'h0000_0100, "roll_hd");
      exp_rd(`RTC_IDX_DATE, 32'h0000_0101, "roll_dt");
      exp_rd(`RTC_IDX_YEAR, 32'h0000_1400, "roll_yr");
      repeat (20) @(posedge ref_clk_i);
      exp_rd(`RTC_IDX_SECMIN, 32'h0000_0000, "stable");
      exp_rd(`RTC_IDX_CTRL, 32'h0000_0001, "run_sts");
      end_test("rollover");

      // Interrupt status, clear and mask
      exp_rd(`RTC_IDX_ISTAT, 32'h0000_0001, "ev_set");
      wr(`RTC_IDX_ISTAT, 32'h1);
      exp_rd(`RTC_IDX_ISTAT, 32'h0000_0000, "ev_clr");
      chk("irq_clr", 32'h0, {31'h0, irq_o});
      wr(`RTC_IDX_IMASK, 32'h0);
      n = 0;
      do begin
         xfer(1'b0, `RTC_IDX_ISTAT, 32'h0);
         n++;
      end while (rdat[`RTC_B_SECEV] !== 1'b1 && n < 100);
      chk("masked_ev", 32'h1, rdat);
      chk("masked_irq", 32'h0, {31'h0, irq_o});
      wr(`RTC_IDX_IMASK, 32'h1);
      repeat (2) @(posedge ref_clk_i);
      chk("unmask_irq", 32'h1, {31'h0, irq_o});
      end_test("interrupt");

      // BCD coding with 12-hour view, 11:59:59 PM rolls to 12 AM
      stop_on(32'h0000_C801);
      wr(`RTC_IDX_SECMIN, 32'h0000_5959);
      wr(`RTC_IDX_HRDAY, 32'h0000_0231);
      exp_rd(`RTC_IDX_HRDAY, 32'h0000_0231, "pm_hour");
      wr(`RTC_IDX_ISTAT, 32'h1);
      wr(`RTC_IDX_CTRL, 32'h0000_C001);
      wait_irq();
      exp_rd(`RTC_IDX_SECMIN, 32'h0000_0000, "bcd_sm");
      exp_rd(`RTC_IDX_HRDAY, 32'h0000_0312, "am_12");
      exp_rd(`RTC_IDX_DATE, 32'h0000_0102, "bcd_dt");
      exp_rd(`RTC_IDX_YEAR, 32'h0000_2000, "bcd_yr");
      end_test("bcd_12h");

      // Tick generator off stops all counting
      wr(`RTC_IDX_CTRL, 32'h0000_0000);
      wr(`RTC_IDX_ISTAT, 32'h1);
      exp_rd(`RTC_IDX_SECMIN, 32'h0000_0000, "pre_off");
      repeat (300) @(posedge ref_clk_i);
      exp_rd(`RTC_IDX_ISTAT, 32'h0000_0000, "tick_off");
      exp_rd(`RTC_IDX_SECMIN, 32'h0000_0000, "frozen");
      chk("off_irq", 32'h0, {31'h0, irq_o});
      end_test("tick_off");

      // External source only: crystal frozen
      xt_run = 1'b0;
      ex_run = 1'b1;
      wr(`RTC_IDX_CTRL, 32'h0000_0003);
      wait_irq();
      exp_rd(`RTC_IDX_CTRL, 32'h0000_0003, "ext_ctrl");
      // Clock enable low freezes counting although the source runs
      wr(`RTC_IDX_ISTAT, 32'h1);
      @(posedge ref_clk_i);
      ce_i <= 1'b0;
      repeat (200) @(posedge ref_clk_i);
      ce_i <= 1'b1;
      exp_rd(`RTC_IDX_ISTAT, 32'h0000_0000, "ce_frozen");
      end_test("ext_source");

      give_verdict();
   end
endmodule
`default_nettype wire
